// ---- pkg/smf_pkg.sv ----
// Package for the SPI status, mode-fault and flag block.
// Assumes one 125 MHz bus clock and a byte-wide register port.
`default_nettype none

package smf_pkg;

    // Register offsets on the byte-wide register port.
    localparam logic [1:0] ADDR_SPI_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_SPI_STATUS_CONTROL = 2'h1;
    localparam logic [1:0] ADDR_SPI_DATA = 2'h2;

    // Field positions in spi_control.
    localparam int CTL_RX_IE = 7;
    localparam int CTL_MASTER = 5;
    localparam int CTL_DMA_SEL = 4;
    localparam int CTL_ENABLE = 1;
    localparam int CTL_TX_IE = 0;

    // Field positions in spi_status_control.
    localparam int STA_RXFULL = 7;
    localparam int STA_ERR_IE = 6;
    localparam int STA_OVR = 5;
    localparam int STA_MODE_FAULT_FLAG = 4;
    localparam int STA_TXEMPTY = 3;
    localparam int STA_MODE_FAULT_FLAG_EN = 2;
    localparam int STA_BAUD_HI = 1;
    localparam int STA_BAUD_LO = 0;

    // Serial clock timing for master mode at the lowest baud select.
    localparam int CLK_PERIOD_NS = 8;
    localparam int SCK_HALF_NS = 80;
    localparam logic [7:0] HALF_CYC = 8'(SCK_HALF_NS / CLK_PERIOD_NS);

    typedef enum logic [1:0] {XF_IDLE, XF_MASTER, XF_SLAVE} smf_xfer_e;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } smf_req_s;

    typedef struct packed {
        logic rx_ie, master, dma_sel, en, tx_ie, err_ie, mode_fault_flag_en;
        logic [1:0] baud;
        logic rxfull, ovr, mode_fault_flag, tx_empty;
        logic rx_arm, ovr_arm, mode_fault_flag_arm;
        logic [7:0] rxdata, txbuf, shift;
        logic samp;
        logic [2:0] bitcnt;
        smf_xfer_e xfer;
        logic [7:0] timer;
        logic sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2, miso_s1, miso_s2;
        logic ss_s1, ss_s2, ss_s3;
        logic [7:0] rdata;
        logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, tx_irq;
    } smf_state_s;

    // Values after reset: flags clear except transmit-empty, select idle.
    localparam smf_state_s SMF_RESET_ST = '{
        tx_empty: 1'b1, ss_s1: 1'b1, ss_s2: 1'b1, ss_s3: 1'b1,
        xfer: XF_IDLE, default: '0};

endpackage

`default_nettype wire

// ---- logic/smf_spi_flags.sv ----
// SPI port flags, mode-fault detection, interrupt gating and byte shifter.
// Assumes serial pins arrive asynchronously and a single-cycle register port.
//
// What this block does
// RULE1 - master drives clock and MOSI, reads MISO
// RULE2 - slave reads clock and MOSI, drives MISO
// RULE3 - slave select rising mid-byte flags fault
// RULE4 - master flags fault when select low
// RULE5 - fault flag sets only when detection enabled
// RULE6 - disabling detection keeps set fault flag
// RULE7 - fault plus error enable raises request
// RULE8 - full, fault, overflow share one request
// RULE9 - enable bit clear partially resets port
// RULE10 - transmit request gated by transmit enable
// RULE11 - transmit empty sets on shifter load
// RULE12 - receiver full sets on byte arrival
// RULE13 - receive request gated by receive enable
// RULE14 - status then data read clears full, unless DMA select is set
// RULE15 - error requests gated by error enable
// RULE16 - byte arriving while full sets overflow
// RULE17 - reset clears receiver full
// RULE18 - no new full while overflow pending
// RULE19 - status read then control write clears fault
// RULE20 - status read then data read clears overflow
`timescale 1ns/1ps
`default_nettype none

module smf_spi_flags
    import smf_pkg::*;
(
    // Clock and reset.
    input wire logic CLK,
    input wire logic RST,
    // Register port.
    input wire smf_req_s REQ,
    output logic [7:0] RDATA,
    // Serial clock pin.
    input wire logic SCK_I,
    output logic SCK_O,
    output logic SCK_OE,
    // Master-out pin.
    input wire logic MOSI_I,
    output logic MOSI_O,
    output logic MOSI_OE,
    // Master-in pin.
    input wire logic MISO_I,
    output logic MISO_O,
    output logic MISO_OE,
    // Slave select, active low.
    input wire logic SS_N_I,
    // Interrupt requests.
    output logic IRQ,
    output logic TX_IRQ
);

    smf_state_s st_ff;
    smf_state_s nxt_st;
    logic byte_done;
    logic [7:0] byte_val;
    logic mode_fault_flag_set;
    logic rd_stat, rd_data, wr_ctrl, wr_stat, wr_data;

    function automatic logic hit(input smf_req_s r, input logic [1:0] a,
                                 input logic is_wr);
        hit = (is_wr ? r.wr : r.rd) && (r.addr == a);
    endfunction

    function automatic logic [7:0] half_cnt(input logic [1:0] b);
        half_cnt = HALF_CYC << b;
    endfunction

    assign rd_stat = hit(REQ, ADDR_SPI_STATUS_CONTROL, 1'b0);
    assign rd_data = hit(REQ, ADDR_SPI_DATA, 1'b0);
    assign wr_ctrl = hit(REQ, ADDR_SPI_CONTROL, 1'b1);
    assign wr_stat = hit(REQ, ADDR_SPI_STATUS_CONTROL, 1'b1);
    assign wr_data = hit(REQ, ADDR_SPI_DATA, 1'b1);

    always_comb begin
        logic clr_rx;
        logic clr_ovr;
        logic clr_mode_fault_flag;
        logic ss_rise;
        logic ss_fall;
        logic sck_rise;
        logic sck_fall;
        clr_rx = 1'b0;
        clr_ovr = 1'b0;
        clr_mode_fault_flag = 1'b0;
        ss_rise = st_ff.ss_s2 && !st_ff.ss_s3;
        ss_fall = !st_ff.ss_s2 && st_ff.ss_s3;
        sck_rise = st_ff.sck_s2 && !st_ff.sck_s3;
        sck_fall = !st_ff.sck_s2 && st_ff.sck_s3;
        byte_done = 1'b0;
        byte_val = 8'h00;
        mode_fault_flag_set = 1'b0;
        nxt_st = st_ff;

        // Two-stage synchronisers; the third stage only feeds edge finding.
        nxt_st.sck_s1 = SCK_I;
        nxt_st.sck_s2 = st_ff.sck_s1;
        nxt_st.sck_s3 = st_ff.sck_s2;
        nxt_st.mosi_s1 = MOSI_I;
        nxt_st.mosi_s2 = st_ff.mosi_s1;
        nxt_st.miso_s1 = MISO_I;
        nxt_st.miso_s2 = st_ff.miso_s1;
        nxt_st.ss_s1 = SS_N_I;
        nxt_st.ss_s2 = st_ff.ss_s1;
        nxt_st.ss_s3 = st_ff.ss_s2;

        // Read data stand only in the cycle after the strobe.
        nxt_st.rdata = 8'h00;
        if (REQ.rd) begin
            case (REQ.addr)
                ADDR_SPI_CONTROL: begin
                    nxt_st.rdata[CTL_RX_IE] = st_ff.rx_ie;
                    nxt_st.rdata[CTL_MASTER] = st_ff.master;
                    nxt_st.rdata[CTL_DMA_SEL] = st_ff.dma_sel;
                    nxt_st.rdata[CTL_ENABLE] = st_ff.en;
                    nxt_st.rdata[CTL_TX_IE] = st_ff.tx_ie;
                end
                ADDR_SPI_STATUS_CONTROL: begin
                    nxt_st.rdata[STA_RXFULL] = st_ff.rxfull;
                    nxt_st.rdata[STA_ERR_IE] = st_ff.err_ie;
                    nxt_st.rdata[STA_OVR] = st_ff.ovr;
                    nxt_st.rdata[STA_MODE_FAULT_FLAG] = st_ff.mode_fault_flag;
                    nxt_st.rdata[STA_TXEMPTY] = st_ff.tx_empty;
                    nxt_st.rdata[STA_MODE_FAULT_FLAG_EN] = st_ff.mode_fault_flag_en;
                    nxt_st.rdata[STA_BAUD_HI:STA_BAUD_LO] = st_ff.baud;
                    // Reading a set flag arms its second clearing step.
                    if (st_ff.rxfull) begin
                        nxt_st.rx_arm = 1'b1; // RULE14
                    end
                    if (st_ff.ovr) begin
                        nxt_st.ovr_arm = 1'b1; // RULE20
                    end
                    if (st_ff.mode_fault_flag) begin
                        nxt_st.mode_fault_flag_arm = 1'b1; // RULE19
                    end
                end
                ADDR_SPI_DATA: begin
                    nxt_st.rdata = st_ff.rxdata;
                end
                default: begin
                    nxt_st.rdata = 8'h00;
                end
            endcase
        end

        if (rd_data) begin
            clr_rx = st_ff.rx_arm && !st_ff.dma_sel; // RULE14
            clr_ovr = st_ff.ovr_arm; // RULE20
            nxt_st.rx_arm = 1'b0;
            nxt_st.ovr_arm = 1'b0;
        end
        if (wr_ctrl) begin
            nxt_st.rx_ie = REQ.wdata[CTL_RX_IE];
            nxt_st.master = REQ.wdata[CTL_MASTER];
            nxt_st.dma_sel = REQ.wdata[CTL_DMA_SEL];
            nxt_st.en = REQ.wdata[CTL_ENABLE];
            nxt_st.tx_ie = REQ.wdata[CTL_TX_IE];
            clr_mode_fault_flag = st_ff.mode_fault_flag_arm; // RULE19
            nxt_st.mode_fault_flag_arm = 1'b0;
        end
        if (wr_stat) begin
            // Flags are read-only here; clearing detection keeps the flag.
            nxt_st.err_ie = REQ.wdata[STA_ERR_IE];
            nxt_st.mode_fault_flag_en = REQ.wdata[STA_MODE_FAULT_FLAG_EN]; // RULE6
            nxt_st.baud = REQ.wdata[STA_BAUD_HI:STA_BAUD_LO];
        end
        if (clr_rx) begin
            nxt_st.rxfull = 1'b0;
        end
        if (clr_ovr) begin
            nxt_st.ovr = 1'b0;
        end
        if (clr_mode_fault_flag) begin
            nxt_st.mode_fault_flag = 1'b0;
        end

        // Mode-fault detection.
        if (st_ff.en && st_ff.mode_fault_flag_en) begin // RULE5
            if (st_ff.master && !st_ff.ss_s2) begin
                mode_fault_flag_set = 1'b1; // RULE4
            end
            // Deselect on a byte boundary ends a frame and is no fault.
            if (!st_ff.master && st_ff.xfer == XF_SLAVE && ss_rise &&
                st_ff.bitcnt != 3'h0) begin
                mode_fault_flag_set = 1'b1; // RULE3
            end
        end

        // Byte shifter, MSB first, sample on rising and shift on falling.
        case (st_ff.xfer)
            XF_IDLE: begin
                nxt_st.sck_o = 1'b0;
                nxt_st.bitcnt = 3'h0;
                if (st_ff.en && st_ff.master && !st_ff.tx_empty &&
                    !st_ff.mode_fault_flag) begin
                    nxt_st.shift = st_ff.txbuf;
                    nxt_st.tx_empty = 1'b1; // RULE11
                    nxt_st.timer = 8'(half_cnt(st_ff.baud) - 8'h01);
                    nxt_st.xfer = XF_MASTER;
                end else if (st_ff.en && !st_ff.master && ss_fall) begin
                    nxt_st.shift = st_ff.txbuf;
                    nxt_st.tx_empty = 1'b1; // RULE11
                    nxt_st.xfer = XF_SLAVE;
                end
            end
            XF_MASTER: begin
                if (!st_ff.en || !st_ff.master || st_ff.mode_fault_flag) begin
                    nxt_st.xfer = XF_IDLE;
                    nxt_st.sck_o = 1'b0;
                end else if (st_ff.timer == 8'h00) begin
                    nxt_st.timer = 8'(half_cnt(st_ff.baud) - 8'h01);
                    nxt_st.sck_o = !st_ff.sck_o;
                    if (!st_ff.sck_o) begin
                        nxt_st.samp = st_ff.miso_s2;
                    end else begin
                        nxt_st.shift = {st_ff.shift[6:0], st_ff.samp};
                        nxt_st.bitcnt = 3'(st_ff.bitcnt + 3'h1);
                        if (st_ff.bitcnt == 3'h7) begin
                            byte_done = 1'b1;
                            byte_val = {st_ff.shift[6:0], st_ff.samp};
                            nxt_st.xfer = XF_IDLE;
                        end
                    end
                end else begin
                    nxt_st.timer = 8'(st_ff.timer - 8'h01);
                end
            end
            XF_SLAVE: begin
                nxt_st.sck_o = 1'b0;
                if (!st_ff.en || st_ff.master || ss_rise) begin
                    nxt_st.xfer = XF_IDLE;
                end else if (sck_rise) begin
                    nxt_st.samp = st_ff.mosi_s2;
                end else if (sck_fall) begin
                    nxt_st.shift = {st_ff.shift[6:0], st_ff.samp};
                    nxt_st.bitcnt = 3'(st_ff.bitcnt + 3'h1);
                    if (st_ff.bitcnt == 3'h7) begin
                        byte_done = 1'b1;
                        byte_val = {st_ff.shift[6:0], st_ff.samp};
                        // Back-to-back bytes reload while select stays low.
                        nxt_st.shift = st_ff.txbuf;
                        nxt_st.tx_empty = 1'b1; // RULE11
                    end
                end
            end
            default: begin
                nxt_st.xfer = XF_IDLE;
            end
        endcase

        // A completed byte wins over a clear made in the same cycle.
        if (byte_done) begin
            if ((!st_ff.rxfull || clr_rx) && !(st_ff.ovr && !clr_ovr)) begin
                nxt_st.rxfull = 1'b1; // RULE12 RULE18
                nxt_st.rxdata = byte_val;
            end else begin
                nxt_st.ovr = 1'b1; // RULE16
            end
        end
        if (mode_fault_flag_set) begin
            nxt_st.mode_fault_flag = 1'b1;
        end

        // Disabling the port drops any byte in flight and sets transmit-empty; other flags survive.
        if (!st_ff.en) begin
            nxt_st.xfer = XF_IDLE; // RULE9
            nxt_st.bitcnt = 3'h0;
            nxt_st.sck_o = 1'b0;
            nxt_st.tx_empty = 1'b1;
        end
        if (wr_data) begin
            nxt_st.txbuf = REQ.wdata;
            nxt_st.tx_empty = 1'b0;
        end

        // Pin direction; a master backs off its pins once a fault is seen.
        nxt_st.sck_oe = nxt_st.en && nxt_st.master && !nxt_st.mode_fault_flag; // RULE1
        nxt_st.mosi_oe = nxt_st.en && nxt_st.master && !nxt_st.mode_fault_flag;
        nxt_st.miso_oe = nxt_st.en && !nxt_st.master && // RULE2
            !nxt_st.ss_s2;
        nxt_st.mosi_o = nxt_st.shift[7];
        nxt_st.miso_o = nxt_st.shift[7];

        // One shared request line for receive and error sources.
        nxt_st.irq = (nxt_st.rxfull && nxt_st.rx_ie) || // RULE8 RULE13
            ((nxt_st.mode_fault_flag || nxt_st.ovr) && nxt_st.err_ie); // RULE7 RULE15
        nxt_st.tx_irq = nxt_st.tx_empty && nxt_st.tx_ie; // RULE10
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_ff <= SMF_RESET_ST; // RULE17
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign RDATA = st_ff.rdata;
    assign SCK_O = st_ff.sck_o;
    assign SCK_OE = st_ff.sck_oe;
    assign MOSI_O = st_ff.mosi_o;
    assign MOSI_OE = st_ff.mosi_oe;
    assign MISO_O = st_ff.miso_o;
    assign MISO_OE = st_ff.miso_oe;
    assign IRQ = st_ff.irq;
    assign TX_IRQ = st_ff.tx_irq;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_stat_rx;
        rd_stat && st_ff.rxfull;
    endsequence
    sequence s_data_rd;
        rd_data && st_ff.rx_arm && !st_ff.dma_sel && !byte_done;
    endsequence
    sequence s_stat_mode_fault_flag;
        rd_stat && st_ff.mode_fault_flag;
    endsequence
    sequence s_stat_ovr;
        rd_stat && st_ff.ovr;
    endsequence

    AST_MASTER_PINS: assert property ( // RULE1
        wr_ctrl && REQ.wdata[CTL_ENABLE] && REQ.wdata[CTL_MASTER] &&
        !st_ff.mode_fault_flag && !st_ff.mode_fault_flag_en |=> SCK_OE && MOSI_OE && !MISO_OE)
        else $error("master mode pins not driven as outputs");
    AST_SLAVE_PINS: assert property ( // RULE2
        wr_ctrl && REQ.wdata[CTL_ENABLE] && !REQ.wdata[CTL_MASTER]
        |=> !SCK_OE && !MOSI_OE)
        else $error("slave mode drives clock or MOSI");
    AST_SLAVE_FAULT: assert property ( // RULE3
        st_ff.en && st_ff.mode_fault_flag_en && !st_ff.master &&
        st_ff.xfer == XF_SLAVE && st_ff.ss_s2 && !st_ff.ss_s3 &&
        st_ff.bitcnt != 3'h0
        |=> st_ff.mode_fault_flag ##1 !SCK_OE)
        else $error("select rise in slave byte missed");
    AST_MASTER_FAULT: assert property ( // RULE4
        st_ff.en && st_ff.mode_fault_flag_en && st_ff.master && !st_ff.ss_s2
        |=> st_ff.mode_fault_flag ##1 !SCK_OE && !MOSI_OE)
        else $error("low select in master mode missed");
    AST_NO_FAULT_OFF: assert property ( // RULE5
        !st_ff.mode_fault_flag_en && !st_ff.mode_fault_flag |=> !st_ff.mode_fault_flag)
        else $error("fault flag set with detection off");
    AST_KEEP_FAULT: assert property ( // RULE6
        st_ff.mode_fault_flag && wr_stat |=> st_ff.mode_fault_flag)
        else $error("fault flag lost on status write");
    AST_SHARED_IRQ: assert property ( // RULE8
        IRQ == ((st_ff.rxfull && st_ff.rx_ie) ||
        ((st_ff.mode_fault_flag || st_ff.ovr) && st_ff.err_ie)))
        else $error("shared request does not match sources");
    AST_TX_IRQ: assert property ( // RULE10
        $rose(st_ff.tx_empty) && st_ff.tx_ie |-> TX_IRQ)
        else $error("transmit request not raised");
    AST_DISABLE: assert property ( // RULE9
        wr_ctrl && !REQ.wdata[CTL_ENABLE] |=> ##1 st_ff.xfer == XF_IDLE &&
        st_ff.tx_empty)
        else $error("disable did not reset shifter");
    AST_RX_CLEAR: assert property ( // RULE14
        s_stat_rx ##[1:8] s_data_rd |=> !st_ff.rxfull)
        else $error("receiver full not cleared");
    AST_RX_SET: assert property ( // RULE12
        byte_done && !st_ff.rxfull && !st_ff.ovr
        |=> st_ff.rxfull && st_ff.rxdata == $past(byte_val))
        else $error("received byte not stored");
    AST_OVERFLOW: assert property ( // RULE16
        byte_done && st_ff.rxfull && !rd_data |=> st_ff.ovr)
        else $error("overflow not flagged");
    AST_OVR_BLOCK: assert property ( // RULE18
        byte_done && st_ff.ovr && !st_ff.rxfull && !rd_data
        |=> !st_ff.rxfull)
        else $error("full set while overflow pending");
    AST_MODE_FAULT_FLAG_CLEAR: assert property ( // RULE19
        s_stat_mode_fault_flag ##[1:8] (wr_ctrl && st_ff.mode_fault_flag_arm && !mode_fault_flag_set)
        |=> !st_ff.mode_fault_flag)
        else $error("fault flag not cleared");
    AST_OVR_CLEAR: assert property ( // RULE20
        s_stat_ovr ##[1:8] (rd_data && st_ff.ovr_arm && !byte_done)
        |=> !st_ff.ovr)
        else $error("overflow flag not cleared");
    AST_RESET_RX: assert property ( // RULE17
        $past(RST) |-> !st_ff.rxfull && !IRQ)
        else $error("receiver full set after reset");

endmodule

`default_nettype wire

// ---- verif/smf_spi_peer.sv ----
// Far-side SPI device model: a mode 0 slave for the block's master role
// and a mode 0 master with a 160 ns link clock for its slave role.
// Assumes the bench resolves the shared pins and sets slave_on and tx_b.
`timescale 1ns/1ps
`default_nettype none

module smf_spi_peer (
    // Resolved serial lines.
    input wire logic sck_i,
    input wire logic mosi_i,
    input wire logic miso_i,
    // Drivers and their enables.
    output logic sck_o,
    output logic sck_oe,
    output logic mosi_o,
    output logic mosi_oe,
    output logic miso_o,
    output logic miso_oe,
    // Select toward the block, active low.
    output logic ss_n_o
);
    logic [7:0] tx_b = 8'h00;
    logic [7:0] rx_b = 8'h00;
    logic slave_on = 1'b0;

    assign miso_oe = slave_on;
    assign miso_o = tx_b[7];

    initial begin
        sck_o = 1'b0;
        sck_oe = 1'b0;
        mosi_o = 1'b0;
        mosi_oe = 1'b0;
        ss_n_o = 1'b1;
    end

    always @(posedge sck_i) begin
        if (slave_on)
            rx_b <= {rx_b[6:0], mosi_i};
    end

    always @(negedge sck_i) begin
        if (slave_on)
            tx_b <= {tx_b[6:0], 1'b0};
    end

    // A count below 8 drops select in mid-byte; only the abort test asks.
    task automatic xfer(input logic [7:0] b, input int nbits);
        tx_b = b;
        sck_oe = 1'b1;
        mosi_oe = 1'b1;
        #203;
        ss_n_o = 1'b0;
        #200;
        for (int i = 0; i < nbits; i++) begin
            mosi_o = tx_b[7];
            #80;
            sck_o = 1'b1;
            rx_b = {rx_b[6:0], miso_i};
            #80;
            sck_o = 1'b0;
            tx_b = {tx_b[6:0], 1'b0};
        end
        #80;
        ss_n_o = 1'b1;
        mosi_oe = 1'b0;
        sck_oe = 1'b0;
    endtask
endmodule

`default_nettype wire

// ---- verif/test_smf_spi_flags.sv ----
// Self-checking bench for the SPI flag block against a far-side peer.
// Assumes the package and the peer model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module test_smf_spi_flags;
    import smf_pkg::*;
    localparam logic [7:0] EN = 8'h01 << CTL_ENABLE;
    localparam logic [7:0] MS = 8'h01 << CTL_MASTER;
    localparam logic [7:0] RIE = 8'h01 << CTL_RX_IE;
    localparam logic [7:0] TIE = 8'h01 << CTL_TX_IE;
    localparam logic [7:0] DS = 8'h01 << CTL_DMA_SEL;
    localparam logic [7:0] EIE = 8'h01 << STA_ERR_IE;
    localparam logic [7:0] MFE = 8'h01 << STA_MODE_FAULT_FLAG_EN;
    localparam logic [7:0] FL = 8'hB8;
    localparam logic [1:0] CTL = ADDR_SPI_CONTROL;
    localparam logic [1:0] STA = ADDR_SPI_STATUS_CONTROL;
    localparam logic [1:0] DAT = ADDR_SPI_DATA;
    logic clk = 1'b0;
    logic rst = 1'b1;
    smf_req_s req = '0;
    logic [7:0] rdata, sent, pb, d, first;
    logic [7:0] rnd = 8'h37;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, irq, tx_irq;
    logic p_sck, p_sck_oe, p_mosi, p_mosi_oe, p_miso, p_miso_oe, ss_n;
    logic mosi_q = 1'b0;
    logic miso_q = 1'b0;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    // Released data lines flip every cycle so a stale bit never passes.
    wire logic sck = sck_oe ? sck_o : (p_sck_oe ? p_sck : 1'b0);
    wire logic mosi = mosi_oe ? mosi_o : (p_mosi_oe ? p_mosi : ~mosi_q);
    wire logic miso = miso_oe ? miso_o : (p_miso_oe ? p_miso : ~miso_q);

    smf_spi_flags dut (.CLK(clk), .RST(rst), .REQ(req), .RDATA(rdata),
        .SCK_I(sck), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi),
        .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso),
        .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_n), .IRQ(irq),
        .TX_IRQ(tx_irq));

    smf_spi_peer peer (.sck_i(sck), .mosi_i(mosi), .miso_i(miso),
        .sck_o(p_sck), .sck_oe(p_sck_oe), .mosi_o(p_mosi),
        .mosi_oe(p_mosi_oe), .miso_o(p_miso), .miso_oe(p_miso_oe),
        .ss_n_o(ss_n));

    always #4 clk = ~clk;

    always @(posedge clk) begin
        mosi_q <= mosi;
        miso_q <= miso;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic logic [7:0] flags(input int rf, ov, mf, te);
        flags = 8'h00;
        flags[STA_RXFULL] = rf[0];
        flags[STA_OVR] = ov[0];
        flags[STA_MODE_FAULT_FLAG] = mf[0];
        flags[STA_TXEMPTY] = te[0];
    endfunction

    task automatic chk8(input string nm, input logic [7:0] e, g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
        #1;
    endtask

    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        #1;
        d = rdata;
    endtask

    // Polling arms the two-step clears, so callers plan around it.
    task automatic wait_bit(input int pos);
        for (int i = 0; i < 300; i++) begin
            rd(STA);
            if (d[pos] === 1'b1)
                break;
        end
    endtask

    task automatic wait_irq;
        for (int i = 0; i < 400 && irq !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic mbyte;
        rnd = lfsr(rnd);
        pb = rnd;
        peer.tx_b = rnd;
        peer.slave_on = 1'b1;
        rnd = lfsr(rnd);
        sent = rnd;
        wr(DAT, sent);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(CTL);
        chk8("control", 8'h00, d);
        rd(STA);
        chk8("status", 8'h08, d);
        rd(2'h3);
        chk8("unmapped", 8'h00, d);
        chk1("tx_irq", 1'b0, tx_irq);
        wr(CTL, EN | MS | TIE);
        chk1("sck_oe", 1'b1, sck_oe);
        chk1("mosi_oe", 1'b1, mosi_oe);
        chk1("miso_oe", 1'b0, miso_oe);
        settle();
        chk1("tx_irq", 1'b1, tx_irq);
        mbyte();
        wait_bit(STA_RXFULL);
        chk1("rxfull", 1'b1, d[STA_RXFULL]);
        chk8("peer rx", sent, peer.rx_b);
        chk1("irq", 1'b0, irq);
        wr(CTL, EN | MS | RIE | DS);
        settle();
        chk1("irq", 1'b1, irq);
        chk1("tx_irq", 1'b0, tx_irq);
        rd(DAT);
        chk8("data", pb, d);
        rd(STA);
        chk8("flags", flags(1, 0, 0, 1), d & FL);
        wr(CTL, EN | MS | RIE);
        rd(DAT);
        rd(STA);
        chk8("flags", flags(0, 0, 0, 1), d & FL);
        // Overflow lands while full is set, then holds off a byte sent after full clears.
        wr(CTL, EN | MS);
        wr(STA, EIE);
        mbyte();
        wait_bit(STA_RXFULL);
        first = pb;
        mbyte();
        wait_irq();
        chk1("irq", 1'b1, irq);
        rd(DAT);
        chk8("kept byte", first, d);
        mbyte();
        repeat (250) @(posedge clk);
        wr(STA, 8'h00);
        settle();
        chk1("irq", 1'b0, irq);
        rd(STA);
        chk8("flags", flags(0, 1, 0, 1), d & FL);
        rd(DAT);
        rd(STA);
        chk8("flags", flags(0, 0, 0, 1), d & FL);
        // Disable in mid-byte.
        wr(CTL, EN | MS);
        mbyte();
        repeat (40) @(posedge clk);
        wr(CTL, MS);
        chk1("sck_oe", 1'b0, sck_oe);
        repeat (250) @(posedge clk);
        rd(STA);
        chk8("flags", flags(0, 0, 0, 1), d & FL);
        rd(CTL);
        chk8("control", MS, d);
        // Select driven low against a master.
        wr(CTL, EN | MS);
        peer.slave_on = 1'b0;
        peer.ss_n_o = 1'b0;
        repeat (20) @(posedge clk);
        rd(STA);
        chk8("flags", flags(0, 0, 0, 1), d & FL);
        wr(STA, MFE | EIE);
        wait_bit(STA_MODE_FAULT_FLAG);
        chk1("mode_fault_flag", 1'b1, d[STA_MODE_FAULT_FLAG]);
        chk1("sck_oe", 1'b0, sck_oe);
        settle();
        chk1("irq", 1'b1, irq);
        wr(STA, EIE);
        rd(STA);
        chk8("flags", flags(0, 0, 1, 1), d & FL);
        wr(CTL, EN | MS);
        settle();
        rd(STA);
        chk8("flags", flags(0, 0, 0, 1), d & FL);
        chk1("irq", 1'b0, irq);
        peer.ss_n_o = 1'b1;
        // Slave role, then a select abort in mid-byte.
        wr(CTL, EN);
        wr(STA, MFE);
        chk1("sck_oe", 1'b0, sck_oe);
        chk1("mosi_oe", 1'b0, mosi_oe);
        rnd = lfsr(rnd);
        sent = rnd;
        wr(DAT, sent);
        rd(STA);
        chk1("tx_empty", 1'b0, d[STA_TXEMPTY]);
        rnd = lfsr(rnd);
        fork
            peer.xfer(rnd, 8);
            begin
                repeat (100) @(posedge clk);
                #1;
                chk1("miso_oe", 1'b1, miso_oe);
                rd(STA);
                chk1("tx_empty", 1'b1, d[STA_TXEMPTY]);
            end
        join
        settle();
        wait_bit(STA_RXFULL);
        chk1("mode_fault_flag", 1'b0, d[STA_MODE_FAULT_FLAG]);
        chk8("peer rx", sent, peer.rx_b);
        rd(DAT);
        chk8("data", rnd, d);
        peer.xfer(rnd, 4);
        wait_bit(STA_MODE_FAULT_FLAG);
        chk1("mode_fault_flag", 1'b1, d[STA_MODE_FAULT_FLAG]);
        tally_and_finish();
    end
endmodule

`default_nettype wire
